//--- src/scc_pkg.sv
// Package for the channel configuration register bank
package scc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SCC_OFS_SHARED_CFG = 8'h07;
  localparam logic [7:0] SCC_OFS_CH0_TV     = 8'h08;
  localparam logic [7:0] SCC_OFS_CH0_EN     = 8'h09;
  localparam logic [7:0] SCC_OFS_CH1_TV     = 8'h0A;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCC_BIT_CH2_STEP   = 4;
  localparam int SCC_BIT_CH1_STEP   = 3;
  localparam int SCC_BIT_CH0_STEP   = 2;
  localparam int SCC_BIT_DRIVE_LSB  = 0;
  localparam int SCC_BIT_DISCHARGE  = 3;
  localparam int SCC_BIT_ENSEL_LSB  = 0;
  localparam logic [7:0] SCC_MASK_SHARED = 8'h1F;
  localparam logic [7:0] SCC_MASK_CH0_EN = 8'h0F;

  // ----------------------------------------------------------------
  // Reset values and decode constants
  // ----------------------------------------------------------------
  localparam logic [7:0] SCC_RST_SHARED = 8'h00;
  localparam logic [7:0] SCC_RST_CH0_TV = 8'h00;
  localparam logic [7:0] SCC_RST_CH0_EN = 8'h00;
  localparam logic [7:0] SCC_RST_CH1_TV = 8'h00;
  localparam logic [7:0] SCC_COARSE_MAX = 8'hC8;
  // Target voltage in units of 0.5 mV: base 0.5 V, steps 25.0/12.5 mV
  localparam logic [13:0] SCC_BASE_HALF_MV   = 14'h03E8;
  localparam logic [5:0]  SCC_COARSE_HALF_MV = 6'h32;
  localparam logic [5:0]  SCC_FINE_HALF_MV   = 6'h19;

  typedef enum logic [2:0]
  {
    SCC_EN_SLOT0 = 3'h0,
    SCC_EN_SLOT1 = 3'h1,
    SCC_EN_SLOT2 = 3'h2,
    SCC_EN_SLOT3 = 3'h3,
    SCC_EN_OFF   = 3'h4,
    SCC_EN_OFF2  = 3'h5,
    SCC_EN_ON    = 3'h6,
    SCC_EN_OFF3  = 3'h7
  } scc_en_sel_t;

  // Applied setting of one channel: latched step size plus code
  typedef struct packed
  {
    logic       fine_step;
    logic [7:0] target_code;
  } scc_chan_set_t;

  // Decoded channel 0 enable
  typedef struct packed
  {
    logic       forced_on;
    logic       forced_off;
    logic       slot_valid;
    logic [1:0] slot;
  } scc_en_dec_t;

endpackage

//--- src/scc_chan_apply.sv
// Per-channel applied setting: latches step size on target write
`timescale 1ns/100ps
module scc_chan_apply
  import scc_pkg::*;
(
  input  wire logic          i_core_clk,   // Core clock
  input  wire logic          i_rst_sync_b, // Synchronised reset, low
  input  wire logic          i_tv_wr,      // Target code written
  input  wire logic [7:0]    i_tv_data,    // Written target code
  input  wire logic          i_fine_step,  // Programmed step select
  output scc_chan_set_t      o_applied,    // Applied step and code
  output logic [13:0]        o_target_hmv, // Target in 0.5 mV units
  output logic               o_reserved    // Applied code is reserved
);

  // ----------------------------------------------------------------
  // Applied setting
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_sync_b)
  begin
    if (!i_rst_sync_b)
    begin
      o_applied <= '0;
    end
    else if (i_tv_wr)
    begin
      // Step change only counts once the code is rewritten
      o_applied.fine_step   <= i_fine_step;
      o_applied.target_code <= i_tv_data;
    end
  end

  // ----------------------------------------------------------------
  // Voltage decode
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_sync_b)
  begin
    if (!i_rst_sync_b)
    begin
      o_target_hmv <= SCC_BASE_HALF_MV;
      o_reserved   <= 1'b0;
    end
    else
    begin
      // Both factors widened first so the product never wraps
      o_target_hmv <= SCC_BASE_HALF_MV
                      + 14'(o_applied.target_code)
                      * 14'(o_applied.fine_step ? SCC_FINE_HALF_MV
                                                : SCC_COARSE_HALF_MV);
      o_reserved   <= !o_applied.fine_step
                      && (o_applied.target_code > SCC_COARSE_MAX);
    end
  end

endmodule

//--- src/scc_config_regs.sv
// Top of the channel configuration register bank
//
// Function
// - Step bit clear gives 25.0 mV steps, set gives 12.5 mV.
// - Step bits: channel 2 bit 4, channel 1 bit 3, channel 0 bit 2.
// - New step size applies only after the target code is rewritten.
// - Fine range 0.5000-3.6875 V; coarse range 0.500-5.500 V.
// - One two-bit drive trim in bits 1:0 serves all channels.
// - Drive codes 0..3 give about 0.6, 1.2, 1.8 and 8 ns edges.
// - Channel 0 target code is bits 7:0, resets zero, read/write.
// - Coarse: 0.5 V + 25 mV x code up to 0xC8; above is reserved.
// - Fine: all codes valid, 0.5 V + 12.5 mV x code.
// - Discharge bit set and channel off switches discharge resistor in.
// - Discharge bit clear leaves resistor out when channel is off.
`timescale 1ns/100ps
module scc_config_regs
  import scc_pkg::*;
#(
  parameter int SEQ_SLOTS = 4 // Sequencer slots reachable
)
(
  input  wire logic          i_core_clk,        // Serial-host clock
  input  wire logic          i_rst_b,           // Async reset, low
  input  wire logic          i_wr_en,           // Register write strobe
  input  wire logic [7:0]    i_addr,            // Register offset
  input  wire logic [7:0]    i_wr_data,         // Write data
  input  wire logic [SEQ_SLOTS-1:0] i_seq_slot_on, // Sequencer slot is up
  output logic [7:0]         o_rd_data,         // Read data
  output logic               o_addr_hit,        // Offset is mapped
  output logic               o_ch2_fine_step_sel, // Channel 2 step select
  output logic [1:0]         o_switch_drive_trim, // Shared drive trim
  output logic [2:0]         o_drive_edge_idx,  // Binary edge speed index
  output scc_chan_set_t      o_ch0_applied,     // Channel 0 applied set
  output scc_chan_set_t      o_ch1_applied,     // Channel 1 applied set
  output logic [13:0]        o_ch0_target_hmv,  // Ch0 target, 0.5 mV
  output logic [13:0]        o_ch1_target_hmv,  // Ch1 target, 0.5 mV
  output logic               o_ch0_code_rsvd,   // Ch0 code reserved
  output logic               o_ch1_code_rsvd,   // Ch1 code reserved
  output logic               o_ch0_enabled,     // Channel 0 is on
  output logic [1:0]         o_ch0_slot,        // Ch0 sequencer slot
  output logic               o_ch0_slot_mode,   // Ch0 follows sequencer
  output logic               o_ch0_discharge_on // Discharge resistor in
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Enable field carries a two-bit slot, so exactly four slots
  if (SEQ_SLOTS != 32'h0000_0004)
  begin : g_chk_slots
    $error("Sequencer slot count must be four");
  end

  // Largest code at coarse step must still fit the 14-bit target
  if (32'(SCC_BASE_HALF_MV) + 32'h0000_00FF * 32'(SCC_COARSE_HALF_MV)
      > 32'h0000_3FFF)
  begin : g_chk_hmv
    $error("Target voltage overflows its output width");
  end

  // Shared offsets would let one write land in two registers
  if (SCC_OFS_SHARED_CFG == SCC_OFS_CH0_TV
      || SCC_OFS_SHARED_CFG == SCC_OFS_CH0_EN
      || SCC_OFS_SHARED_CFG == SCC_OFS_CH1_TV
      || SCC_OFS_CH0_TV == SCC_OFS_CH0_EN
      || SCC_OFS_CH0_TV == SCC_OFS_CH1_TV
      || SCC_OFS_CH0_EN == SCC_OFS_CH1_TV)
  begin : g_chk_ofs
    $error("Register offsets must be distinct");
  end

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  function automatic scc_en_dec_t decode_en(input logic [2:0] code);
    scc_en_dec_t d;
    d = '0;
    case (scc_en_sel_t'(code))
      SCC_EN_SLOT0, SCC_EN_SLOT1, SCC_EN_SLOT2, SCC_EN_SLOT3:
      begin
        d.slot_valid = 1'b1;
        d.slot       = code[1:0];
      end
      SCC_EN_ON:
      begin
        d.forced_on = 1'b1;
      end
      default:
      begin
        // Codes 4, 5 and 7 all hold the channel off
        d.forced_off = 1'b1;
      end
    endcase
    decode_en = d;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] shared_step_drive_config;
  logic [7:0] channel0_target_voltage;
  logic [7:0] channel0_enable_discharge;
  logic [7:0] channel1_target_voltage;
  logic       wr_shared;
  logic       wr_ch0_tv;
  logic       wr_ch0_en;
  logic       wr_ch1_tv;

  assign wr_shared = i_wr_en && addr_is(i_addr, SCC_OFS_SHARED_CFG);
  assign wr_ch0_tv = i_wr_en && addr_is(i_addr, SCC_OFS_CH0_TV);
  assign wr_ch0_en = i_wr_en && addr_is(i_addr, SCC_OFS_CH0_EN);
  assign wr_ch1_tv = i_wr_en && addr_is(i_addr, SCC_OFS_CH1_TV);

  always_ff @(posedge i_core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      shared_step_drive_config <= SCC_RST_SHARED;
    end
    else if (wr_shared)
    begin
      // Bits 7:5 stay zero; channel 3 step lives elsewhere
      shared_step_drive_config <= i_wr_data & SCC_MASK_SHARED;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      channel0_target_voltage <= SCC_RST_CH0_TV;
    end
    else if (wr_ch0_tv)
    begin
      channel0_target_voltage <= i_wr_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      channel0_enable_discharge <= SCC_RST_CH0_EN;
    end
    else if (wr_ch0_en)
    begin
      channel0_enable_discharge <= i_wr_data & SCC_MASK_CH0_EN;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      channel1_target_voltage <= SCC_RST_CH1_TV;
    end
    else if (wr_ch1_tv)
    begin
      channel1_target_voltage <= i_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    o_addr_hit = 1'b1;
    case (i_addr)
      SCC_OFS_SHARED_CFG: o_rd_data = shared_step_drive_config;
      SCC_OFS_CH0_TV:     o_rd_data = channel0_target_voltage;
      SCC_OFS_CH0_EN:     o_rd_data = channel0_enable_discharge;
      SCC_OFS_CH1_TV:     o_rd_data = channel1_target_voltage;
      default:
      begin
        o_rd_data  = 8'h00;
        o_addr_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Step size and drive trim
  // ----------------------------------------------------------------
  logic ch0_fine_step_sel;
  logic ch1_fine_step_sel;

  assign ch0_fine_step_sel   = shared_step_drive_config[SCC_BIT_CH0_STEP];
  assign ch1_fine_step_sel   = shared_step_drive_config[SCC_BIT_CH1_STEP];
  assign o_ch2_fine_step_sel = shared_step_drive_config[SCC_BIT_CH2_STEP];
  // One trim for every channel: the switches share one inductor
  assign o_switch_drive_trim =
    shared_step_drive_config[SCC_BIT_DRIVE_LSB +: 2];

  // Edge speed index 0 fastest .. 3 slowest (~0.6/1.2/1.8/8 ns)
  always_ff @(posedge i_core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      o_drive_edge_idx <= 3'h0;
    end
    else
    begin
      o_drive_edge_idx <= {1'b0, o_switch_drive_trim};
    end
  end

  // ----------------------------------------------------------------
  // Applied channel settings
  // ----------------------------------------------------------------
  scc_chan_apply u_ch0_apply
  (
    .i_core_clk   (i_core_clk),
    .i_rst_sync_b (rst_sync_b),
    .i_tv_wr      (wr_ch0_tv),
    .i_tv_data    (i_wr_data),
    .i_fine_step  (ch0_fine_step_sel),
    .o_applied    (o_ch0_applied),
    .o_target_hmv (o_ch0_target_hmv),
    .o_reserved   (o_ch0_code_rsvd)
  );

  scc_chan_apply u_ch1_apply
  (
    .i_core_clk   (i_core_clk),
    .i_rst_sync_b (rst_sync_b),
    .i_tv_wr      (wr_ch1_tv),
    .i_tv_data    (i_wr_data),
    .i_fine_step  (ch1_fine_step_sel),
    .o_applied    (o_ch1_applied),
    .o_target_hmv (o_ch1_target_hmv),
    .o_reserved   (o_ch1_code_rsvd)
  );

  // ----------------------------------------------------------------
  // Channel 0 enable and discharge
  // ----------------------------------------------------------------
  scc_en_dec_t ch0_en_dec;
  logic        ch0_discharge_en;
  logic        next_ch0_enabled;

  assign ch0_en_dec = decode_en(
    channel0_enable_discharge[SCC_BIT_ENSEL_LSB +: 3]);
  assign ch0_discharge_en = channel0_enable_discharge[SCC_BIT_DISCHARGE];

  always_comb
  begin
    next_ch0_enabled = 1'b0;
    if (ch0_en_dec.forced_on)
    begin
      next_ch0_enabled = 1'b1;
    end
    else if (ch0_en_dec.slot_valid)
    begin
      next_ch0_enabled = i_seq_slot_on[ch0_en_dec.slot];
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      o_ch0_enabled      <= 1'b0;
      o_ch0_slot         <= 2'h0;
      o_ch0_slot_mode    <= 1'b0;
      o_ch0_discharge_on <= 1'b0;
    end
    else
    begin
      o_ch0_enabled      <= next_ch0_enabled;
      o_ch0_slot         <= ch0_en_dec.slot;
      o_ch0_slot_mode    <= ch0_en_dec.slot_valid;
      // Resistor only while off, else it would load the live rail
      o_ch0_discharge_on <= ch0_discharge_en
                            && !next_ch0_enabled;
    end
  end

endmodule

//--- tb/scc_config_regs_assertions.sv
// Concurrent checks on the channel configuration register bank ports
`timescale 1ns/100ps
module scc_config_regs_chk
  import scc_pkg::*;
(
  input wire logic          i_core_clk,          // Clock
  input wire logic          i_rst_b,             // Async reset, low
  input wire logic          i_wr_en,             // Write strobe
  input wire logic [7:0]    i_addr,              // Offset
  input wire logic [7:0]    i_wr_data,           // Write data
  input wire logic [7:0]    o_rd_data,           // Read data
  input wire logic          o_addr_hit,          // Offset mapped
  input wire logic          o_ch2_fine_step_sel, // Ch2 step
  input wire logic [1:0]    o_switch_drive_trim, // Drive trim
  input wire logic [2:0]    o_drive_edge_idx,    // Edge speed
  input wire scc_chan_set_t o_ch0_applied,       // Ch0 applied
  input wire scc_chan_set_t o_ch1_applied,       // Ch1 applied
  input wire logic [13:0]   o_ch0_target_hmv,    // Ch0 target
  input wire logic [13:0]   o_ch1_target_hmv,    // Ch1 target
  input wire logic          o_ch0_enabled,       // Ch0 on
  input wire logic          o_ch0_discharge_on   // Discharge in
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  sequence wr0_s;
    i_wr_en && i_addr == SCC_OFS_CH0_TV;
  endsequence
  sequence wr1_s;
    i_wr_en && i_addr == SCC_OFS_CH1_TV;
  endsequence
  sequence no_wr0_s;
    !(i_wr_en && i_addr == SCC_OFS_CH0_TV);
  endsequence
  sequence no_wr1_s;
    !(i_wr_en && i_addr == SCC_OFS_CH1_TV);
  endsequence
  // Quiet cycle after the write so a rewrite cannot mask the result
  sequence on_s;
    i_wr_en && i_addr == SCC_OFS_CH0_EN && i_wr_data[2:0] == 3'h6
      ##1 !i_wr_en;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  ch0_code_load_a: assert property (wr0_s |=>
    o_ch0_applied.target_code == $past(i_wr_data))
    else $error("ch0 code not loaded");
  ch1_code_load_a: assert property (wr1_s |=>
    o_ch1_applied.target_code == $past(i_wr_data))
    else $error("ch1 code not loaded");
  ch0_hold_a: assert property (
    no_wr0_s |=> $stable(o_ch0_applied))
    else $error("ch0 applied moved without write");
  ch1_hold_a: assert property (
    no_wr1_s |=> $stable(o_ch1_applied))
    else $error("ch1 applied moved without write");
  ch0_volt_a: assert property (o_ch0_target_hmv == 14'h3E8 +
    $past(o_ch0_applied.target_code) *
    ($past(o_ch0_applied.fine_step) ? 14'h19 : 14'h32))
    else $error("ch0 target voltage wrong");
  ch1_volt_a: assert property (o_ch1_target_hmv == 14'h3E8 +
    $past(o_ch1_applied.target_code) *
    ($past(o_ch1_applied.fine_step) ? 14'h19 : 14'h32))
    else $error("ch1 target voltage wrong");
  drive_follow_a: assert property (
    o_drive_edge_idx == {1'b0, $past(o_switch_drive_trim)})
    else $error("edge speed does not follow trim");
  trim_read_a: assert property (i_addr == SCC_OFS_SHARED_CFG |->
    o_rd_data[1:0] == o_switch_drive_trim)
    else $error("trim field mismatch");
  step2_read_a: assert property (i_addr == SCC_OFS_SHARED_CFG |->
    o_rd_data[4] == o_ch2_fine_step_sel)
    else $error("ch2 step bit mismatch");
  unmapped_zero_a: assert property (!o_addr_hit |-> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  force_on_a: assert property (on_s |=> o_ch0_enabled)
    else $error("code 6 did not turn ch0 on");
  discharge_gate_a: assert property (o_ch0_discharge_on |->
    !o_ch0_enabled)
    else $error("discharge while channel on");
endmodule

bind scc_config_regs scc_config_regs_chk u_chk (.i_core_clk, .i_rst_b,
  .i_wr_en, .i_addr, .i_wr_data, .o_rd_data, .o_addr_hit,
  .o_ch2_fine_step_sel, .o_switch_drive_trim, .o_drive_edge_idx,
  .o_ch0_applied, .o_ch1_applied, .o_ch0_target_hmv, .o_ch1_target_hmv,
  .o_ch0_enabled, .o_ch0_discharge_on);

//--- tb/scc_config_regs_bench.sv
// Self-checking bench for the channel configuration register bank
`timescale 1ns/100ps
module scc_config_regs_bench import scc_pkg::*;;
  logic          i_core_clk = 1'b0;
  logic          i_rst_b = 1'b0;
  logic          i_wr_en = 1'b0;
  logic [7:0]    i_addr = 8'h00;
  logic [7:0]    i_wr_data = 8'h00;
  logic [3:0]    i_seq_slot_on = 4'h5;
  logic [7:0]    o_rd_data;
  logic [1:0]    o_switch_drive_trim, o_ch0_slot;
  logic [2:0]    o_drive_edge_idx;
  logic [13:0]   o_ch0_target_hmv, o_ch1_target_hmv;
  scc_chan_set_t o_ch0_applied, o_ch1_applied;
  logic          o_addr_hit, o_ch2_fine_step_sel, o_ch0_code_rsvd;
  logic          o_ch1_code_rsvd, o_ch0_enabled, o_ch0_slot_mode;
  logic          o_ch0_discharge_on;
  int            err_count = 0;
  int            n_checks = 0;

  scc_config_regs u_dut (.i_core_clk, .i_rst_b, .i_wr_en, .i_addr,
    .i_wr_data, .i_seq_slot_on, .o_rd_data, .o_addr_hit,
    .o_ch2_fine_step_sel, .o_switch_drive_trim, .o_drive_edge_idx,
    .o_ch0_applied, .o_ch1_applied, .o_ch0_target_hmv, .o_ch1_target_hmv,
    .o_ch0_code_rsvd, .o_ch1_code_rsvd, .o_ch0_enabled, .o_ch0_slot,
    .o_ch0_slot_mode, .o_ch0_discharge_on);

  always #5 i_core_clk = ~i_core_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge i_core_clk);
    i_wr_en   <= 1'b1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_core_clk);
    i_wr_en   <= 1'b0;
  endtask

  // Registered outputs lag the write by up to two edges
  task automatic settle;
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, exp);
    @(posedge i_core_clk);
    i_addr <= a;
    #1;
    chk("rd_data", o_rd_data, exp);
  endtask

  task automatic close_out;
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdchk(SCC_OFS_SHARED_CFG, 8'h00);
    rdchk(SCC_OFS_CH0_TV, 8'h00);
    rdchk(SCC_OFS_CH0_EN, 8'h00);
    rdchk(SCC_OFS_CH1_TV, 8'h00);
    chk("ch0_hmv", o_ch0_target_hmv, 16'h03E8);
  endtask

  task automatic t_rw;
    wr(8'h06, 8'hFF);
    wr(8'h0B, 8'hFF);
    rdchk(8'h0B, 8'h00);
    chk("addr_hit", o_addr_hit, 16'h0000);
    wr(SCC_OFS_SHARED_CFG, 8'hFF);
    wr(SCC_OFS_CH0_TV, 8'hFF);
    wr(SCC_OFS_CH0_EN, 8'hFF);
    wr(SCC_OFS_CH1_TV, 8'hFF);
    rdchk(SCC_OFS_SHARED_CFG, 8'h1F);
    rdchk(SCC_OFS_CH0_TV, 8'hFF);
    rdchk(SCC_OFS_CH0_EN, 8'h0F);
  endtask

  // Rows: step config, target offset, code, half-mV target, reserved
  task automatic t_step;
    logic [47:0]   tab [6];
    scc_chan_set_t ap;
    logic [15:0]   hmv;
    logic          rsvd;
    logic          is0;
    int            sb;
    tab = '{48'h00_08_C8_2AF8_00, 48'h00_08_C9_2B2A_01,
            48'h04_08_FF_1CCF_00, 48'h08_0A_FF_1CCF_00,
            48'h04_0A_10_0708_00, 48'h08_08_00_03E8_00};
    foreach (tab[i])
    begin
      wr(SCC_OFS_SHARED_CFG, tab[i][47:40]);
      wr(tab[i][39:32], tab[i][31:24]);
      settle;
      is0  = (tab[i][39:32] == SCC_OFS_CH0_TV);
      // Each channel reads its own step bit of the shared config
      sb   = 40 + (is0 ? SCC_BIT_CH0_STEP : SCC_BIT_CH1_STEP);
      ap   = is0 ? o_ch0_applied : o_ch1_applied;
      hmv  = is0 ? 16'(o_ch0_target_hmv) : 16'(o_ch1_target_hmv);
      rsvd = is0 ? o_ch0_code_rsvd : o_ch1_code_rsvd;
      chk("code", ap.target_code, tab[i][31:24]);
      chk("step", ap.fine_step, tab[i][sb]);
      chk("hmv", hmv, tab[i][23:8]);
      chk("rsvd", rsvd, tab[i][7:0]);
    end
  endtask

  task automatic t_late_step;
    wr(SCC_OFS_SHARED_CFG, 8'h00);
    wr(SCC_OFS_CH0_TV, 8'h40);
    wr(SCC_OFS_SHARED_CFG, 8'h04);
    settle;
    chk("hmv_held", o_ch0_target_hmv, 16'h1068);
    wr(SCC_OFS_CH0_TV, 8'h40);
    settle;
    chk("hmv_new", o_ch0_target_hmv, 16'h0A28);
  endtask

  task automatic t_drive;
    for (int k = 0; k < 4; k++)
    begin
      wr(SCC_OFS_SHARED_CFG, 8'h10 | 8'(k));
      settle;
      chk("trim", o_switch_drive_trim, 16'(k));
      chk("edge", o_drive_edge_idx, 16'(k));
      chk("ch2_step", o_ch2_fine_step_sel, 16'h0001);
    end
  endtask

  task automatic t_enable;
    logic en;
    for (int c = 0; c < 8; c++)
    begin
      wr(SCC_OFS_CH0_EN, 8'h08 | 8'(c));
      settle;
      en = (c == 6) ? 1'b1 : (c < 4) ? i_seq_slot_on[c] : 1'b0;
      chk("enabled", o_ch0_enabled, en);
      chk("discharge", o_ch0_discharge_on, !en);
      chk("slot_mode", o_ch0_slot_mode, c < 4);
      if (c < 4)
        chk("slot", o_ch0_slot, 16'(c));
    end
    wr(SCC_OFS_CH0_EN, 8'h09);
    i_seq_slot_on <= 4'hA;
    settle;
    chk("slot_up", o_ch0_enabled, 16'h0001);
    chk("dis_off", o_ch0_discharge_on, 16'h0000);
    wr(SCC_OFS_CH0_EN, 8'h04);
    settle;
    chk("no_dis", o_ch0_discharge_on, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    #100000;
    err_count++;
    close_out;
  end

  initial
  begin
    repeat (4) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    t_reset;
    t_rw;
    t_step;
    t_late_step;
    t_drive;
    t_enable;
    @(posedge i_core_clk);
    i_rst_b <= 1'b0;
    rdchk(SCC_OFS_CH0_TV, 8'h00);
    close_out;
  end
endmodule
